// File: rtl/hsis_pkg.sv
// Package: register map, field layout and state encoding of the interrupt microframe scheduler
package hsis_pkg;
  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_DESC     = 12'h000;
  localparam logic [11:0] OFF_FRAME    = 12'h004;
  localparam logic [11:0] OFF_CNT_BASE = 12'h008;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h018;
  localparam logic [11:0] OFF_IRQ_CLR  = 12'h01c;
  localparam logic [11:0] OFF_IRQ_EN   = 12'h020;
  localparam int          CNT_REGS     = 4;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int UFRAMES    = 8;
  localparam int RES_W      = 3;
  localparam int RES_LSB    = 8;
  localparam int RES_ERR    = 0;
  localparam int RES_BABBLE = 1;
  localparam int RES_UNDER  = 2;
  localparam int FRAME_LSB  = 3;
  localparam int FRAME_W    = 5;
  localparam int CNT_W      = 12;
  localparam int CNT_HI_LSB = 16;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_ERR    = 1;
  localparam int IRQ_EMPTY  = 2;
  localparam int IRQ_W      = 3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]       RST_MASK  = 8'h00;
  localparam logic [7:0]       RST_FRAME = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ   = 3'h0;

  typedef enum logic [0:0] {HSIS_IDLE = 1'b0, HSIS_WAIT = 1'b1} hsis_state_e;
endpackage

// File: rtl/hsis_sched_if.sv
// Interface: links between the register file and the microframe sequencer
`timescale 1ns/100ps
`default_nettype none
interface hsis_sched_if;
  logic [7:0]  mask;
  logic [4:0]  frame_field;
  logic        issue;
  logic [2:0]  issue_uf;
  logic        res_wr;
  logic [2:0]  res_uf;
  logic [2:0]  result;
  logic        cnt_wr;
  logic [11:0] cnt;

  modport sched (
    input  mask, frame_field,
    output issue, issue_uf, res_wr, res_uf, result, cnt_wr, cnt
  );
  modport regs (
    output mask, frame_field,
    input  issue, issue_uf, res_wr, res_uf, result, cnt_wr, cnt
  );
endinterface
`default_nettype wire

// File: rtl/hsis_uframe_seq.sv
// Microframe sequencer: issues gated transactions and forms their results
`timescale 1ns/100ps
`default_nettype none
module hsis_uframe_seq (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        uframe_start_in,
  input  wire logic [2:0]  uframe_idx_in,
  input  wire logic [4:0]  bus_frame_in,
  input  wire logic        done_in,
  input  wire logic        in_token_in,
  input  wire logic        err_in,
  input  wire logic        babble_in,
  input  wire logic        underrun_in,
  input  wire logic [11:0] bytes_in,
  hsis_sched_if.sched      sif
);
  hsis_pkg::hsis_state_e state_r;
  logic                  match;

  assign match = (bus_frame_in == sif.frame_field) && sif.mask[uframe_idx_in];

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r      <= hsis_pkg::HSIS_IDLE;
      sif.issue    <= 1'b0;
      sif.issue_uf <= 3'h0;
      sif.res_wr   <= 1'b0;
      sif.res_uf   <= 3'h0;
      sif.result   <= 3'h0;
      sif.cnt_wr   <= 1'b0;
      sif.cnt      <= 12'h000;
    end else begin
      sif.issue  <= 1'b0;
      sif.res_wr <= 1'b0;
      sif.cnt_wr <= 1'b0;
      unique case (state_r)
        hsis_pkg::HSIS_IDLE: begin
          if (uframe_start_in && match) begin
            sif.issue    <= 1'b1;
            sif.issue_uf <= uframe_idx_in;
            state_r      <= hsis_pkg::HSIS_WAIT;
          end
        end
        hsis_pkg::HSIS_WAIT: begin
          if (done_in) begin
            sif.res_wr                       <= 1'b1;
            sif.res_uf                       <= sif.issue_uf;
            sif.result[hsis_pkg::RES_ERR]    <= err_in;
            sif.result[hsis_pkg::RES_BABBLE] <= babble_in & in_token_in;
            sif.result[hsis_pkg::RES_UNDER]  <= underrun_in & ~in_token_in;
            sif.cnt_wr                       <= in_token_in;
            sif.cnt                          <= bytes_in;
            state_r                          <= hsis_pkg::HSIS_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_issue_gated: assert property (
    uframe_start_in && !match |=> !sif.issue) else $error("issue without matching frame and mask");
  a_issue_taken: assert property (
    uframe_start_in && match && state_r == hsis_pkg::HSIS_IDLE |=> sif.issue && sif.issue_uf == $past(uframe_idx_in))
    else $error("matching microframe not issued");
  a_result_after_xact: assert property (
    sif.res_wr |-> $past(done_in) && $past(state_r) == hsis_pkg::HSIS_WAIT) else $error("result without transaction");
  a_err_bit_copy: assert property (
    sif.res_wr |-> sif.result[0] == $past(err_in)) else $error("error bit mismatch");
  a_babble_in_only: assert property (
    sif.res_wr && sif.result[1] |-> $past(in_token_in) && $past(babble_in)) else $error("babble on out token");
  a_underrun_out_only: assert property (
    sif.res_wr && sif.result[2] |-> !$past(in_token_in) && $past(underrun_in)) else $error("underrun on in token");
  c_issue_done: cover property (sif.issue ##[1:20] sif.res_wr);
endmodule
`default_nettype wire

// File: rtl/hsis_sched_top.sv
// Top: APB register file, interrupt logic and sequencer of the interrupt microframe scheduler
`timescale 1ns/100ps
`default_nettype none

module hsis_sched_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        UFRAME_START_IN,
  input  wire logic [2:0]  UFRAME_IDX_IN,
  input  wire logic [4:0]  BUS_FRAME_IN,
  input  wire logic        XACT_DONE_IN,
  input  wire logic        XACT_IN_TOKEN_IN,
  input  wire logic        XACT_ERR_IN,
  input  wire logic        XACT_BABBLE_IN,
  input  wire logic        XACT_UNDERRUN_IN,
  input  wire logic [11:0] XACT_BYTES_IN,
  output logic             XACT_REQ_OUT,
  output logic      [2:0]  XACT_UFRAME_OUT,
  output logic             IRQ_OUT
);
  // ****************************************************************
  // Declarations
  // ****************************************************************
  hsis_sched_if sif ();

  logic [7:0]                  mask_r;
  logic [7:0]                  mask_nxt;
  logic [7:0]                  mask_set;
  logic [7:0]                  mask_clr;
  logic [7:0]                  frame_r;
  logic [hsis_pkg::RES_W-1:0]  res_r [hsis_pkg::UFRAMES];
  logic [hsis_pkg::CNT_W-1:0]  cnt_r [hsis_pkg::UFRAMES];
  logic [hsis_pkg::IRQ_W-1:0]  irq_stat_r;
  logic [hsis_pkg::IRQ_W-1:0]  irq_stat_nxt;
  logic [hsis_pkg::IRQ_W-1:0]  irq_en_r;
  logic [hsis_pkg::IRQ_W-1:0]  irq_ev;
  logic [hsis_pkg::IRQ_W-1:0]  irq_clr;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;
  logic                        irq_r;
  logic                        acc_first;
  logic                        wr_en;
  logic                        wr_desc;
  logic [31:0]                 rd_word;

  // ****************************************************************
  // Address decoding
  // ****************************************************************
  function automatic logic addr_ok(input logic [11:0] addr);
    logic ok;
    ok = (addr == hsis_pkg::OFF_DESC) || (addr == hsis_pkg::OFF_FRAME) ||
         (addr == hsis_pkg::OFF_IRQ_STAT) || (addr == hsis_pkg::OFF_IRQ_CLR) ||
         (addr == hsis_pkg::OFF_IRQ_EN);
    for (int k = 0; k < hsis_pkg::CNT_REGS; k++) begin
      ok = ok || (addr == hsis_pkg::OFF_CNT_BASE + 12'(4 * k));
    end
    return ok;
  endfunction

  assign acc_first = PSEL_IN && PENABLE_IN && !pready_r;
  assign wr_en     = PSEL_IN && PENABLE_IN && pready_r && PWRITE_IN && addr_ok(PADDR_IN);
  assign wr_desc   = wr_en && (PADDR_IN == hsis_pkg::OFF_DESC);

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always_comb begin
    rd_word = 32'h0000_0000;
    if (PADDR_IN == hsis_pkg::OFF_DESC) begin
      rd_word[7:0] = mask_r;
      for (int k = 0; k < hsis_pkg::UFRAMES; k++) begin
        rd_word[hsis_pkg::RES_LSB + hsis_pkg::RES_W * k +: hsis_pkg::RES_W] = res_r[k];
      end
    end else if (PADDR_IN == hsis_pkg::OFF_FRAME) begin
      rd_word[7:0] = frame_r;
    end else if (PADDR_IN == hsis_pkg::OFF_IRQ_STAT) begin
      rd_word[hsis_pkg::IRQ_W-1:0] = irq_stat_r;
    end else if (PADDR_IN == hsis_pkg::OFF_IRQ_EN) begin
      rd_word[hsis_pkg::IRQ_W-1:0] = irq_en_r;
    end else begin
      for (int k = 0; k < hsis_pkg::CNT_REGS; k++) begin
        if (PADDR_IN == hsis_pkg::OFF_CNT_BASE + 12'(4 * k)) begin
          rd_word[hsis_pkg::CNT_W-1:0] = cnt_r[2 * k];
          rd_word[hsis_pkg::CNT_HI_LSB +: hsis_pkg::CNT_W] = cnt_r[2 * k + 1];
        end
      end
    end
  end

  // ****************************************************************
  // APB handshake: one wait state, answer on the second access cycle
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc_first;
      pslverr_r <= acc_first && !addr_ok(PADDR_IN);
      if (acc_first && !PWRITE_IN) begin
        prdata_r <= rd_word;
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // ****************************************************************
  // Activation mask: software sets, hardware clears, set wins
  // ****************************************************************
  always_comb begin
    mask_set = wr_desc ? PWDATA_IN[7:0] : 8'h00;
    mask_clr = 8'h00;
    if (sif.res_wr) begin
      mask_clr[sif.res_uf] = 1'b1;
    end
    mask_nxt = (mask_r & ~mask_clr) | mask_set;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mask_r <= hsis_pkg::RST_MASK;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // ****************************************************************
  // Frame field of descriptor word two
  // ****************************************************************
  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      frame_r <= hsis_pkg::RST_FRAME;
    end else if (wr_en && PADDR_IN == hsis_pkg::OFF_FRAME) begin
      frame_r <= PWDATA_IN[7:0];
    end
  end

  assign sif.mask        = mask_r;
  assign sif.frame_field = frame_r[hsis_pkg::FRAME_LSB +: hsis_pkg::FRAME_W];

  // ****************************************************************
  // Per-microframe results and received byte counts
  // ****************************************************************
  generate
    for (genvar g = 0; g < hsis_pkg::UFRAMES; g++) begin : g_uf
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          res_r[g] <= 3'h0;
        end else if (sif.res_wr && sif.res_uf == 3'(g)) begin
          res_r[g] <= sif.result;
        end
      end
      always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
          cnt_r[g] <= 12'h000;
        end else if (sif.cnt_wr && sif.res_uf == 3'(g)) begin
          cnt_r[g] <= sif.cnt;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Interrupt status, enable and clear
  // ****************************************************************
  always_comb begin
    irq_ev                      = 3'h0;
    irq_ev[hsis_pkg::IRQ_DONE]  = sif.res_wr;
    irq_ev[hsis_pkg::IRQ_ERR]   = sif.res_wr && (sif.result != 3'h0);
    irq_ev[hsis_pkg::IRQ_EMPTY] = sif.res_wr && (mask_r != 8'h00) && (mask_nxt == 8'h00);
    irq_clr = (wr_en && PADDR_IN == hsis_pkg::OFF_IRQ_CLR) ? PWDATA_IN[hsis_pkg::IRQ_W-1:0] : 3'h0;
    irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_ev;
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_stat_r <= hsis_pkg::RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_en_r <= hsis_pkg::RST_IRQ;
    end else if (wr_en && PADDR_IN == hsis_pkg::OFF_IRQ_EN) begin
      irq_en_r <= PWDATA_IN[hsis_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(irq_stat_r & irq_en_r);
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  hsis_uframe_seq u_seq (
    .clk_in          (CORE_CLK_IN),
    .rst_n_in        (RST_N_IN),
    .uframe_start_in (UFRAME_START_IN),
    .uframe_idx_in   (UFRAME_IDX_IN),
    .bus_frame_in    (BUS_FRAME_IN),
    .done_in         (XACT_DONE_IN),
    .in_token_in     (XACT_IN_TOKEN_IN),
    .err_in          (XACT_ERR_IN),
    .babble_in       (XACT_BABBLE_IN),
    .underrun_in     (XACT_UNDERRUN_IN),
    .bytes_in        (XACT_BYTES_IN),
    .sif             (sif.sched)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign PRDATA_OUT      = prdata_r;
  assign PREADY_OUT      = pready_r;
  assign PSLVERR_OUT     = pslverr_r;
  assign XACT_REQ_OUT    = sif.issue;
  assign XACT_UFRAME_OUT = sif.issue_uf;
  assign IRQ_OUT         = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_mask_hw_clear: assert property (
    sif.res_wr && !(wr_desc && PWDATA_IN[sif.res_uf]) |=> !mask_r[$past(sif.res_uf)])
    else $error("mask bit not cleared after microframe");
  a_mask_sw_no_drop: assert property (
    wr_desc && !sif.res_wr |=> (mask_r & $past(mask_r)) == $past(mask_r))
    else $error("software write lowered a mask bit");
  a_mask_set_wins: assert property (
    wr_desc && sif.res_wr && PWDATA_IN[sif.res_uf] |=> mask_r[$past(sif.res_uf)])
    else $error("clear beat simultaneous set");
  a_result_stored: assert property (
    sif.res_wr |=> res_r[$past(sif.res_uf)] == $past(sif.result)) else $error("result not stored");
  a_count_stored: assert property (
    sif.cnt_wr |=> cnt_r[$past(sif.res_uf)] == $past(sif.cnt)) else $error("byte count not stored");
  a_issue_needs_mask: assert property (
    sif.issue |-> $past(mask_r[UFRAME_IDX_IN]) && $past(BUS_FRAME_IN) == $past(sif.frame_field))
    else $error("issue with mask bit low");
  a_irq_follows: assert property (
    ##1 irq_r == $past(|(irq_stat_r & irq_en_r))) else $error("irq level wrong");
  a_apb_answer: assert property (
    PSEL_IN && PENABLE_IN && !pready_r |=> pready_r ##1 !pready_r) else $error("apb answer timing");

  a_irq_set_wins: assert property (
    |(irq_ev & irq_clr) |=> (irq_stat_r & $past(irq_ev)) == $past(irq_ev))
    else $error("status clear beat simultaneous event");
  a_status_sticky: assert property (
    (irq_stat_r & ~irq_clr) != 3'h0 |=> (irq_stat_r & $past(irq_stat_r & ~irq_clr)) == $past(irq_stat_r & ~irq_clr))
    else $error("status bit dropped without clear");
  a_read_idle_zero: assert property (
    !pready_r |-> prdata_r == 32'h0000_0000) else $error("read data outside answer cycle");
  a_slverr_with_ready: assert property (
    pslverr_r |-> pready_r) else $error("slave error without ready");

  c_err_result: cover property (sif.res_wr && sif.result[0]);
  c_mask_empty: cover property (irq_ev[hsis_pkg::IRQ_EMPTY]);
  c_set_and_clear: cover property (wr_desc && sif.res_wr);
endmodule
`default_nettype wire

// File: verification/hsis_usb_dev_model.sv
// Partner model: high-speed interrupt endpoint answering issued transactions
`timescale 1ns/100ps
`default_nettype none
module hsis_usb_dev_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        req_in,
  input  wire logic [2:0]  dly_in,
  input  wire logic        in_tok_in,
  input  wire logic        err_in,
  input  wire logic        babble_in,
  input  wire logic        under_in,
  input  wire logic [11:0] bytes_in,
  output logic             done_out,
  output logic             in_tok_out,
  output logic             err_out,
  output logic             babble_out,
  output logic             under_out,
  output logic      [11:0] bytes_out
);
  logic       busy_r;
  logic [2:0] wait_r;

  // ****************************************************************
  // Answer each request after dly_in cycles with one done pulse
  // ****************************************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r   <= 1'b0;
      wait_r   <= 3'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (req_in) begin
        busy_r <= 1'b1;
        wait_r <= dly_in;
      end else if (busy_r) begin
        if (wait_r <= 3'h1) begin
          busy_r   <= 1'b0;
          done_out <= 1'b1;
        end else begin
          wait_r <= wait_r - 3'h1;
        end
      end
    end
  end

  // Outcome lines carry the inverse outside the done cycle
  assign in_tok_out = done_out ? in_tok_in : ~in_tok_in;
  assign err_out    = done_out ? err_in : ~err_in;
  assign babble_out = done_out ? babble_in : ~babble_in;
  assign under_out  = done_out ? under_in : ~under_in;
  assign bytes_out  = done_out ? bytes_in : ~bytes_in;
endmodule
`default_nettype wire

// File: verification/tb.sv
// Testbench: self-checking bench of the interrupt microframe scheduler
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h0309cd88;
  logic        pready, pslverr, uf_start = 1'b0, xdone, xin, xerr, xbab, xund, xreq, irq;
  logic [2:0]  uf_idx = 3'h0, xuf, c_dly = 3'h1, stat_m, en_m;
  logic [4:0]  bus_frame = 5'h00;
  logic [11:0] xbytes, c_bytes = 12'h000, cnt_m[8];
  logic        c_in = 1'b0, c_err = 1'b0, c_bab = 1'b0, c_und = 1'b0;
  logic [7:0]  mask_m, frame_m;
  logic [2:0]  res_m[8];
  int          mismatches = 0, checks = 0;

  always #12.5 clk = ~clk;

  hsis_sched_top u_hsis_sched_top (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .UFRAME_START_IN(uf_start), .UFRAME_IDX_IN(uf_idx), .BUS_FRAME_IN(bus_frame),
    .XACT_DONE_IN(xdone), .XACT_IN_TOKEN_IN(xin), .XACT_ERR_IN(xerr), .XACT_BABBLE_IN(xbab),
    .XACT_UNDERRUN_IN(xund), .XACT_BYTES_IN(xbytes), .XACT_REQ_OUT(xreq), .XACT_UFRAME_OUT(xuf), .IRQ_OUT(irq));

  hsis_usb_dev_model u_hsis_usb_dev_model (.clk_in(clk), .rst_n_in(rst_n), .req_in(xreq), .dly_in(c_dly),
    .in_tok_in(c_in), .err_in(c_err), .babble_in(c_bab), .under_in(c_und), .bytes_in(c_bytes),
    .done_out(xdone), .in_tok_out(xin), .err_out(xerr), .babble_out(xbab), .under_out(xund), .bytes_out(xbytes));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] desc_exp();
    logic [31:0] e;
    e = {24'h0, mask_m};
    for (int k = 0; k < 8; k++) e[8+3*k +: 3] = res_m[k];
    return e;
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready and read data are taken at the rising edge that samples ready high
    @(posedge clk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    if (n >= 40) chk("apb_ready", 32'h1, 32'h0);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name, input logic eerr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(name, exp, rd);
    chk("pslverr", {31'h0, eerr}, {31'h0, err});
  endtask

  // One microframe: start, expected issue, partner answer, model update
  task automatic do_uframe(input int i);
    logic [31:0] o;
    logic        exp_req, seen;
    logic [2:0]  r;
    int          n;
    o = rnd();
    exp_req = (bus_frame == frame_m[7:3]) && mask_m[i];
    seen = 1'b0;
    @(posedge clk);
    c_in     <= o[0];
    c_err    <= o[1];
    c_bab    <= o[2];
    c_und    <= o[3];
    c_bytes  <= o[27:16];
    c_dly    <= {1'b0, o[30:29]} + 3'h1;
    uf_start <= 1'b1;
    uf_idx   <= i[2:0];
    @(posedge clk);
    uf_start <= 1'b0;
    uf_idx   <= ~i[2:0];
    for (n = 0; n < 3 && !seen; n++) begin
      @(negedge clk);
      seen = (xreq === 1'b1);
    end
    chk("xact_req", {31'h0, exp_req}, {31'h0, seen});
    if (seen) begin
      chk("xact_uframe", i, {29'h0, xuf});
      n = 0;
      while (xdone !== 1'b1 && n < 10) begin
        @(negedge clk);
        n++;
      end
      r = {~c_in & c_und, c_in & c_bab, c_err};
      res_m[i] = r;
      if (c_in) cnt_m[i] = c_bytes;
      mask_m[i] = 1'b0;
      stat_m |= 3'h1;
      if (r != 3'h0) stat_m |= 3'h2;
      if (mask_m == 8'h00) stat_m |= 3'h4;
      repeat (4) @(negedge clk);
      chk("irq", {31'h0, |(stat_m & en_m)}, {31'h0, irq});
    end
    rd_chk(hsis_pkg::OFF_DESC, desc_exp(), "desc", 1'b0);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] o;
    logic [7:0]  fb;
    for (int k = 0; k < 8; k++) begin
      res_m[k] = 3'h0;
      cnt_m[k] = 12'h000;
    end
    {mask_m, frame_m, stat_m, en_m} = '0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(hsis_pkg::OFF_DESC, 32'h0, "desc_reset", 1'b0);
    rd_chk(hsis_pkg::OFF_FRAME, 32'h0, "frame_reset", 1'b0);
    rd_chk(hsis_pkg::OFF_IRQ_EN, 32'h0, "irq_en_reset", 1'b0);
    rd_chk(12'h024, 32'h0, "unmapped", 1'b1);
    for (int rn = 0; rn < 6; rn++) begin
      o = rnd();
      fb = (rn == 0) ? 8'h00 : o[7:0];
      wr(hsis_pkg::OFF_FRAME, {24'h0, fb});
      frame_m = fb;
      bus_frame <= (rn == 3) ? fb[7:3] + 5'h01 : fb[7:3];
      wr(hsis_pkg::OFF_IRQ_EN, {29'h0, o[10:8]});
      en_m = o[10:8];
      wr(hsis_pkg::OFF_DESC, {24'h0, o[23:16]});
      mask_m |= o[23:16];
      wr(hsis_pkg::OFF_DESC, 32'hffffff00);
      rd_chk(hsis_pkg::OFF_FRAME, {24'h0, frame_m}, "frame", 1'b0);
      for (int k = 0; k < 8; k++) do_uframe(k);
      for (int j = 0; j < 4; j++)
        rd_chk(hsis_pkg::OFF_CNT_BASE + 12'(4 * j), {4'h0, cnt_m[2*j+1], 4'h0, cnt_m[2*j]}, "count", 1'b0);
      wr(hsis_pkg::OFF_IRQ_STAT, 32'hffffffff);
      rd_chk(hsis_pkg::OFF_IRQ_STAT, {29'h0, stat_m}, "irq_status", 1'b0);
      rd_chk(hsis_pkg::OFF_IRQ_CLR, 32'h0, "irq_clear", 1'b0);
      wr(hsis_pkg::OFF_IRQ_CLR, {29'h0, o[26:24]});
      stat_m &= ~o[26:24];
      repeat (3) @(negedge clk);
      chk("irq_after_clear", {31'h0, |(stat_m & en_m)}, {31'h0, irq});
      rd_chk(hsis_pkg::OFF_IRQ_STAT, {29'h0, stat_m}, "irq_status", 1'b0);
    end
    print_verdict();
  end

  // Watchdog well beyond the expected run of about a thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
